// ### rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] REG_CONTROL_A = 8'h00;
  localparam logic [7:0] REG_CHANNEL_SELECT = 8'h01;
  localparam logic [7:0] REG_CONTROL_B = 8'h03;
  localparam logic [7:0] REG_RESULT_LOW = 8'h04;
  localparam logic [7:0] REG_RESULT_HIGH = 8'h05;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h06;
  localparam logic [7:0] REG_IRQ_MASK = 8'h07;

  // Reset values
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // Field positions of converter control A
  localparam int CTLA_ENABLE_BIT = 7;
  localparam int CTLA_START_BIT = 6;
  localparam int CTLA_AUTO_BIT = 5;
  localparam logic [7:0] CTLA_STORE_MASK = 8'hBF;

  // Field positions of channel select register and control B
  localparam int CHSEL_LEFT_ADJUST_BIT = 5;
  localparam int CTLB_BIPOLAR_BIT = 7;
  localparam int CTLB_POLARITY_BIT = 5;
  localparam logic [7:0] CTLB_WRITE_MASK = 8'hE7;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;

  // Result format limits
  localparam logic signed [11:0] UNI_MAX = 12'sh3FF;
  localparam logic signed [11:0] BIP_MAX = 12'sh1FF;
  localparam logic signed [11:0] BIP_MIN = -12'sh200;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [5:0] PAD_ZERO = 6'h00;

  // Trigger source codes
  typedef enum logic [2:0] {
    TRIG_FREE_RUN = 3'b000,
    TRIG_COMPARATOR = 3'b001,
    TRIG_EXT_INT0 = 3'b010,
    TRIG_T0_MATCH_A = 3'b011,
    TRIG_T0_OVERFLOW = 3'b100,
    TRIG_T0_MATCH_B = 3'b101,
    TRIG_PIN_CHANGE = 3'b110,
    TRIG_NONE = 3'b111
  } trig_src_t;

  // Conversion phase
  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_phase_t;

  // Peripheral interrupt flags that may trigger a conversion
  typedef struct packed {
    logic pinChange;
    logic t0MatchB;
    logic t0Overflow;
    logic t0MatchA;
    logic extInt0;
    logic comparator;
  } trigger_flags_t;

  // Answer from the analogue converter: positive minus negative input
  typedef struct packed {
    logic done;
    logic signed [10:0] diff;
  } conv_answer_t;

  // Whole state of the control block
  typedef struct packed {
    conv_phase_t phase;
    logic [7:0] ctrlA;
    logic [7:0] chanSel;
    logic [7:0] ctrlB;
    logic [9:0] result;
    logic locked;
    logic prevTrig;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [7:0] rdData;
    logic startPulse;
  } adc_state_t;

endpackage

// ### rtl/adc_result_and_trigger_control.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE1] Finished conversion loads 10-bit result bits 9:0
// [RULE2] Low byte read locks result until high read
// [RULE3] Software reads low byte before high byte
// [RULE4] Left adjust bit aligns result to top
// [RULE5] Unipolar at reset; bipolar bit 7 selects bipolar
// [RULE6] Bipolar two's complement; unipolar unsigned ten bits
// [RULE7] Unipolar non-positive input saturates to reference
// [RULE8] Polarity reversal bit 5 swaps input pair
// [RULE9] Control B bits 4:3 read zero
// [RULE10] Trigger field acts only with auto enable
// [RULE11] Rising edge of selected flag starts conversion
// [RULE12] Switching to set flag triggers if enabled
// [RULE13] Selecting free running never makes trigger event
// [RULE14] Codes 000 to 011 decode first four sources
// [RULE15] Codes 100 to 110 decode timer, pin sources
// [RULE16] Code 111 selects no trigger at all
module adc_result_and_trigger_control
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire trigger_flags_t trigFlags,
  input wire conv_answer_t convAnswer,
  output logic convStart,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Pick the interrupt flag of the chosen trigger source
  function automatic logic selectFlag(
    input logic [2:0] code,
    input trigger_flags_t flags
  );
    logic f;
    f = 1'b0;
    case (trig_src_t'(code))
      TRIG_COMPARATOR: f = flags.comparator; // [RULE14]
      TRIG_EXT_INT0: f = flags.extInt0; // [RULE14]
      TRIG_T0_MATCH_A: f = flags.t0MatchA; // [RULE14]
      TRIG_T0_OVERFLOW: f = flags.t0Overflow; // [RULE15]
      TRIG_T0_MATCH_B: f = flags.t0MatchB; // [RULE15]
      TRIG_PIN_CHANGE: f = flags.pinChange; // [RULE15]
      TRIG_NONE: f = 1'b0; // [RULE16]
      default: f = 1'b0; // Free running has no flag edge [RULE13]
    endcase
    return f;
  endfunction

  // Shape the raw difference into the stored result format
  function automatic logic [9:0] formatResult(
    input logic signed [10:0] diff,
    input logic bipolar,
    input logic reversed
  );
    logic signed [11:0] d;
    logic signed [11:0] h;
    logic [9:0] r;
    d = reversed ? -{diff[10], diff} : {diff[10], diff}; // [RULE8]
    h = d >>> 1;
    r = FULL_SCALE;
    if (bipolar) begin
      // Nine magnitude bits plus sign [RULE6]
      if (h > BIP_MAX) begin
        r = BIP_MAX[9:0];
      end else if (h < BIP_MIN) begin
        r = BIP_MIN[9:0];
      end else begin
        r = h[9:0];
      end
    end else if (d <= 12'sh000 || d > UNI_MAX) begin
      // Wrong-sided or over range input saturates [RULE7]
      r = FULL_SCALE;
    end else begin
      r = d[9:0]; // Unsigned ten bit result [RULE6]
    end
    return r;
  endfunction

  // Present one byte of the result in the chosen alignment
  function automatic logic [7:0] resultByte(
    input logic [9:0] res,
    input logic leftAdjust,
    input logic highByte
  );
    logic [7:0] b;
    if (leftAdjust) begin
      b = highByte ? res[9:2] : {res[1:0], PAD_ZERO}; // [RULE4]
    end else begin
      b = highByte ? {PAD_ZERO, res[9:8]} : res[7:0]; // [RULE4]
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State

  adc_state_t s_q; // Registered state
  adc_state_t s_d; // Next state

  logic busy; // Conversion in progress
  logic enabled; // Converter enable bit
  logic autoEn; // Auto trigger enable bit
  logic curTrig; // Selected trigger flag now
  logic trigEdge; // Rising edge on selected flag
  logic swStart; // Software start request
  logic freeRestart; // Free running restart at completion
  logic readLow; // Low byte read this cycle
  logic readHigh; // High byte read this cycle
  logic [7:0] newCtrlA; // Control A after this cycle's write

  //////////////////////////////////////////////////////////////////////////
  // Decoded helpers

  // Simple decodes shared by next state logic and checks
  always_comb begin
    busy = (s_q.phase == CONV_BUSY);
    enabled = s_q.ctrlA[CTLA_ENABLE_BIT];
    autoEn = s_q.ctrlA[CTLA_AUTO_BIT];
    curTrig = selectFlag(s_q.ctrlB[2:0], trigFlags);
    trigEdge = curTrig & ~s_q.prevTrig; // [RULE11] [RULE12]
    readLow = regRead && (regAddr == REG_RESULT_LOW);
    readHigh = regRead && (regAddr == REG_RESULT_HIGH);
    newCtrlA = s_q.ctrlA;
    swStart = 1'b0;
    if (regWrite && (regAddr == REG_CONTROL_A)) begin
      newCtrlA = regWrData & CTLA_STORE_MASK;
      swStart = regWrData[CTLA_START_BIT];
    end
    freeRestart = autoEn && convAnswer.done &&
      (trig_src_t'(s_q.ctrlB[2:0]) == TRIG_FREE_RUN);
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state

  // Register writes, conversion sequencing, result lock and reads
  always_comb begin
    s_d = s_q;
    s_d.startPulse = 1'b0;
    s_d.rdData = 8'h00;
    s_d.prevTrig = curTrig;
    s_d.ctrlA = newCtrlA;

    // Register writes, address decode
    if (regWrite) begin
      if (regAddr == REG_CHANNEL_SELECT) begin
        s_d.chanSel = regWrData;
      end else if (regAddr == REG_CONTROL_B) begin
        s_d.ctrlB = regWrData & CTLB_WRITE_MASK; // [RULE5] [RULE9]
      end else if (regAddr == REG_IRQ_STATUS) begin
        s_d.irqStatus = s_q.irqStatus & ~regWrData[1:0];
      end else if (regAddr == REG_IRQ_MASK) begin
        s_d.irqMask = regWrData[1:0];
      end
    end

    // Conversion sequencing
    if (!busy) begin
      // Auto start only while the enable bit is set [RULE10] [RULE12]
      // Software start also counts an enable written in the same cycle
      if ((swStart && newCtrlA[CTLA_ENABLE_BIT]) ||
        (enabled && autoEn && trigEdge)) begin
        s_d.phase = CONV_BUSY;
        s_d.startPulse = 1'b1;
      end
    end else if (convAnswer.done) begin
      s_d.phase = CONV_IDLE;
      // A held result drops the new one [RULE2]
      if (s_q.locked || readLow) begin
        s_d.irqStatus[IRQ_LOST_BIT] = 1'b1;
      end else begin
        s_d.result = formatResult(convAnswer.diff,
          s_q.ctrlB[CTLB_BIPOLAR_BIT],
          s_q.ctrlB[CTLB_POLARITY_BIT]); // [RULE1]
      end
      s_d.irqStatus[IRQ_DONE_BIT] = 1'b1;
      // Free running restarts on completion, while enabled
      if (enabled && freeRestart) begin
        s_d.phase = CONV_BUSY;
        s_d.startPulse = 1'b1;
      end
    end else if (!enabled) begin
      s_d.phase = CONV_IDLE; // Disable aborts the conversion
    end

    // Register reads, data stands the following cycle
    if (regRead) begin
      if (regAddr == REG_CONTROL_A) begin
        s_d.rdData = s_q.ctrlA;
        s_d.rdData[CTLA_START_BIT] = busy;
      end else if (regAddr == REG_CHANNEL_SELECT) begin
        s_d.rdData = s_q.chanSel;
      end else if (regAddr == REG_CONTROL_B) begin
        s_d.rdData = s_q.ctrlB & CTLB_WRITE_MASK; // [RULE9]
      end else if (readLow) begin
        s_d.rdData = resultByte(s_q.result,
          s_q.chanSel[CHSEL_LEFT_ADJUST_BIT], 1'b0);
        s_d.locked = 1'b1; // [RULE2] [RULE3]
      end else if (readHigh) begin
        s_d.rdData = resultByte(s_q.result,
          s_q.chanSel[CHSEL_LEFT_ADJUST_BIT], 1'b1);
        s_d.locked = 1'b0; // [RULE2] [RULE3]
      end else if (regAddr == REG_IRQ_STATUS) begin
        s_d.rdData = {6'h00, s_q.irqStatus};
      end else if (regAddr == REG_IRQ_MASK) begin
        s_d.rdData = {6'h00, s_q.irqMask};
      end else begin
        s_d.rdData = 8'h00; // Unmapped reads zero
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  // Whole block state in one register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.phase <= CONV_IDLE;
      s_q.ctrlA <= CONTROL_A_RESET;
      s_q.chanSel <= CHANNEL_SELECT_RESET;
      s_q.ctrlB <= CONTROL_B_RESET; // Unipolar at reset [RULE5]
      s_q.result <= RESULT_RESET;
      s_q.locked <= 1'b0;
      s_q.prevTrig <= 1'b0;
      s_q.irqStatus <= IRQ_RESET;
      s_q.irqMask <= IRQ_RESET;
      s_q.rdData <= 8'h00;
      s_q.startPulse <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Registered data and pulse, level interrupt
  always_comb begin
    regRdData = s_q.rdData;
    convStart = s_q.startPulse;
    irq = |(s_q.irqStatus & s_q.irqMask);
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  logic quietBus; // No control A write this cycle
  assign quietBus = !(regWrite && (regAddr == REG_CONTROL_A));

  result_load_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done && !s_q.locked && !readLow |=>
      s_q.result == formatResult($past(convAnswer.diff),
        $past(s_q.ctrlB[CTLB_BIPOLAR_BIT]),
        $past(s_q.ctrlB[CTLB_POLARITY_BIT])))
    else $error("Result not loaded at completion");

  result_lock_a: assert property ( // [RULE2]
    @(posedge clk) disable iff (!reset_n)
    readLow ##1 (!readHigh && !regRead) [*2] |-> $stable(s_q.result))
    else $error("Result changed while locked");

  lost_result_a: assert property ( // [RULE2]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done && (s_q.locked || readLow) |=>
      $stable(s_q.result) && s_q.irqStatus[IRQ_LOST_BIT])
    else $error("Locked result overwritten");

  done_flag_a: assert property ( // [RULE1]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done |=> s_q.irqStatus[IRQ_DONE_BIT])
    else $error("Completion flag not set");

  left_adjust_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    readHigh && s_q.chanSel[CHSEL_LEFT_ADJUST_BIT] |=>
      regRdData == $past(s_q.result[9:2]))
    else $error("High byte not left aligned");

  right_adjust_a: assert property ( // [RULE4]
    @(posedge clk) disable iff (!reset_n)
    readHigh && !s_q.chanSel[CHSEL_LEFT_ADJUST_BIT] |=>
      regRdData == {PAD_ZERO, $past(s_q.result[9:8])})
    else $error("High byte not right aligned");

  bipolar_sign_a: assert property ( // [RULE6]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done && !s_q.locked && !readLow &&
      s_q.ctrlB[CTLB_BIPOLAR_BIT] && !s_q.ctrlB[CTLB_POLARITY_BIT] &&
      convAnswer.diff[10] |=> s_q.result[9])
    else $error("Bipolar negative result lost sign");

  unipolar_sat_a: assert property ( // [RULE7]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done && !s_q.locked && !readLow &&
      !s_q.ctrlB[CTLB_BIPOLAR_BIT] && !s_q.ctrlB[CTLB_POLARITY_BIT] &&
      convAnswer.diff <= 11'sh000 |=> s_q.result == FULL_SCALE)
    else $error("Unipolar result not saturated");

  polarity_swap_a: assert property ( // [RULE8]
    @(posedge clk) disable iff (!reset_n)
    busy && convAnswer.done && !s_q.locked && !readLow &&
      !s_q.ctrlB[CTLB_BIPOLAR_BIT] && s_q.ctrlB[CTLB_POLARITY_BIT] &&
      convAnswer.diff < 11'sh000 && convAnswer.diff > -11'sh3FF |=>
      s_q.result == 10'(-$past(convAnswer.diff)))
    else $error("Reversed pair not measured");

  reserved_zero_a: assert property ( // [RULE9]
    @(posedge clk) disable iff (!reset_n)
    regRead && regAddr == REG_CONTROL_B |=> regRdData[4:3] == 2'b00)
    else $error("Reserved bits not zero");

  auto_off_a: assert property ( // [RULE10]
    @(posedge clk) disable iff (!reset_n)
    !autoEn && quietBus |=> !convStart)
    else $error("Start without auto enable");

  edge_start_a: assert property ( // [RULE11] [RULE12]
    @(posedge clk) disable iff (!reset_n)
    !busy && enabled && autoEn && trigEdge |=> convStart && busy)
    else $error("Trigger edge did not start conversion");

  busy_ignore_a: assert property ( // [RULE11]
    @(posedge clk) disable iff (!reset_n)
    busy && !convAnswer.done |=> !convStart)
    else $error("Start while conversion busy");

  free_quiet_a: assert property ( // [RULE13]
    @(posedge clk) disable iff (!reset_n)
    !busy && quietBus &&
      trig_src_t'(s_q.ctrlB[2:0]) == TRIG_FREE_RUN |=> !convStart)
    else $error("Free running selection made a trigger");

  no_source_a: assert property ( // [RULE16]
    @(posedge clk) disable iff (!reset_n)
    !busy && quietBus &&
      trig_src_t'(s_q.ctrlB[2:0]) == TRIG_NONE |=> !convStart)
    else $error("Unused code made a trigger");

endmodule

// ### verif/adc_result_and_trigger_control_test.sv
`timescale 1ns/1ns
module adc_result_and_trigger_control_test
  import adc_ctrl_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic clk = 1'b0; // System clock, 8 ns period
  logic reset_n = 1'b0; // Async reset, active low
  logic [ADDR_W-1:0] regAddr = '0; // Register address
  logic [DATA_W-1:0] regWrData = '0; // Write data
  logic regWrite = 1'b0; // Write strobe
  logic regRead = 1'b0; // Read strobe
  logic [DATA_W-1:0] regRdData; // Read data, one cycle after strobe
  trigger_flags_t trigFlags = '0; // Peripheral event flags
  conv_answer_t convAnswer = '0; // Converter answer
  logic convStart; // Conversion start pulse
  logic irq; // Interrupt level
  int errors = 0; // Mismatch count
  int n_checks = 0; // Comparison count
  int starts = 0; // Start pulses seen so far

  ////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #4 clk = ~clk;

  adc_result_and_trigger_control dut_u (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .trigFlags(trigFlags),
    .convAnswer(convAnswer), .convStart(convStart), .irq(irq)
  );

  // Counts one-cycle start pulses
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      starts++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [7:0] exp);
    logic [7:0] v;
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdData;
    chk(name, v, exp);
  endtask

  // Result read, low byte first so the pair stays coherent
  task automatic res_chk(input logic [7:0] hi, input logic [7:0] lo);
    rd_chk("low", REG_RESULT_LOW, lo);
    rd_chk("high", REG_RESULT_HIGH, hi);
  endtask

  // Converter finishes with the given difference
  task automatic finish(input logic [10:0] d);
    @(posedge clk);
    convAnswer <= {1'b1, d};
    @(posedge clk);
    convAnswer <= '0;
    @(posedge clk);
  endtask

  // Start by software, then finish
  task automatic conv(input logic [10:0] d);
    int s0;
    s0 = starts;
    wr(REG_CONTROL_A, 8'hC0);
    repeat (2) @(posedge clk);
    chk("start", 8'(starts - s0), 8'h01);
    finish(d);
  endtask

  // Waits and compares the number of new starts
  task automatic starts_chk(input int s0, input logic [7:0] exp);
    repeat (4) @(posedge clk);
    chk("starts", 8'(starts - s0), exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_regs;
    rd_chk("ctlb", REG_CONTROL_B, 8'h00);
    res_chk(8'h00, 8'h00);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(REG_CONTROL_B, 8'hFF);
    rd_chk("ctlb", REG_CONTROL_B, 8'hE7);
    wr(REG_CONTROL_B, 8'h01);
    rd_chk("unmapped", 8'h02, 8'h00);
  endtask

  task automatic t_formats;
    conv(11'h2A5);
    res_chk(8'h02, 8'hA5);
    wr(REG_CHANNEL_SELECT, 8'h20);
    conv(11'h2A5);
    res_chk(8'hA9, 8'h40);
    wr(REG_CHANNEL_SELECT, 8'h00);
    conv(11'h7FB);
    res_chk(8'h03, 8'hFF);
    wr(REG_CONTROL_B, 8'h21);
    conv(11'h7FB);
    res_chk(8'h00, 8'h05);
    wr(REG_CONTROL_B, 8'h81);
    conv(11'h79C);
    res_chk(8'h03, 8'hCE);
    wr(REG_CONTROL_B, 8'h01);
  endtask

  task automatic t_lock_irq;
    conv(11'h2A5);
    wr(REG_IRQ_STATUS, 8'h03);
    wr(REG_IRQ_MASK, 8'h01);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    rd_chk("low", REG_RESULT_LOW, 8'hA5);
    conv(11'h155);
    chk("irq", {7'h0, irq}, 8'h01);
    rd_chk("high", REG_RESULT_HIGH, 8'h02);
    res_chk(8'h02, 8'hA5);
    rd_chk("status", REG_IRQ_STATUS, 8'h03);
    wr(REG_IRQ_STATUS, 8'h03);
    #1 chk("irq", {7'h0, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h00);
  endtask

  task automatic t_triggers;
    int s0;
    wr(REG_CONTROL_A, 8'hA0);
    // Each listed source starts a conversion on its rising flag
    for (int c = 1; c <= 6; c++) begin
      wr(REG_CONTROL_B, 8'(c));
      s0 = starts;
      @(posedge clk);
      trigFlags <= 6'(1 << (c - 1));
      starts_chk(s0, 8'h01);
      finish(11'h010);
      trigFlags <= '0;
    end
    // Unlisted code never triggers
    wr(REG_CONTROL_B, 8'h07);
    s0 = starts;
    @(posedge clk);
    trigFlags <= 6'h3F;
    starts_chk(s0, 8'h00);
    // Switching from a clear flag to a set flag triggers
    trigFlags <= 6'h01;
    wr(REG_CONTROL_B, 8'h02);
    s0 = starts;
    wr(REG_CONTROL_B, 8'h01);
    starts_chk(s0, 8'h01);
    finish(11'h010);
    // Without auto enable the field does nothing
    wr(REG_CONTROL_A, 8'h80);
    trigFlags <= 6'h00;
    s0 = starts;
    @(posedge clk);
    trigFlags <= 6'h01;
    starts_chk(s0, 8'h00);
    // Selecting free running with done flag set makes no event
    wr(REG_CONTROL_A, 8'hA0);
    // Leave from a clear flag so a done-flag source would show an edge
    wr(REG_CONTROL_B, 8'h02);
    s0 = starts;
    wr(REG_CONTROL_B, 8'h00);
    starts_chk(s0, 8'h00);
    // Free running restarts when each conversion completes
    s0 = starts;
    wr(REG_CONTROL_A, 8'hE0);
    finish(11'h010);
    starts_chk(s0, 8'h02);
    wr(REG_CONTROL_A, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_regs();
    t_formats();
    t_lock_irq();
    t_triggers();
    stop_test();
  end

  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
